//--- hw/uartdec_defs.vh
// Purpose: Constants for the dual-channel register decoder.
// Assumes: Included by hw/uartdec_top.v only.
// Notes:   Locations are the 3-bit register select values.
//
// What this block does
// - Each channel keeps its own register set, picked by its select.
// - Three select bits pick one of eight locations, banked by mode bits.
// - Line-control bit 7 low: location 0 is rx/tx data, 1 interrupt enable.
// - Bit 7 high, not 0xBF: locations 0 and 1 are divisor low/high.
// - Divisor access with divisor zero: reads give revision and device id.
// - Not 0xBF: location 2 reads interrupt status, writes fifo control.
// - Location 3 always reaches line control.
// - Normal bank: location 4 is modem control.
// - Normal bank: location 5 reads line status, writes ignored.
// - Normal bank: location 6 reads modem status, writes ignored.
// - Not 0xBF, swap bit clear: location 7 is the scratch byte.
// - Not 0xBF, swap bit set: 7 reads fifo level, writes mode select.
// - 0xBF: location 0 trigger/count, 1 feature control, 2 enhanced function.
// - 0xBF: locations 4 to 7 hold the four flow characters.
// - Enhanced upper bits act only with enhanced-function bit 4 set.
`ifndef UARTDEC_DEFS_VH
`define UARTDEC_DEFS_VH

// ==================================================
// Locations
`define UARTDEC_LOC_0       3'h0
`define UARTDEC_LOC_1       3'h1
`define UARTDEC_LOC_2       3'h2
`define UARTDEC_LOC_LINE    3'h3
`define UARTDEC_LOC_4       3'h4
`define UARTDEC_LOC_5       3'h5
`define UARTDEC_LOC_6       3'h6
`define UARTDEC_LOC_7       3'h7

// ==================================================
// Mode values and bit positions
`define UARTDEC_ENH_KEY     8'hbf
`define UARTDEC_DIV_BIT     7
`define UARTDEC_SWAP_BIT    6
`define UARTDEC_ENH_EN_BIT  4
`define UARTDEC_IER_ENH     8'hf0
`define UARTDEC_ISR_ENH     8'h30
`define UARTDEC_FCR_ENH     8'h30
`define UARTDEC_MCR_ENH     8'he0

// ==================================================
// Reset values
`define UARTDEC_RST_BYTE    8'h00
`define UARTDEC_RST_DIV     16'h0000
// Selects and strobes idle high, address and data low
`define UARTDEC_RST_SYNC    15'h6300
`define UARTDEC_SYNC_W      15

`endif

//--- hw/uartdec_top.v
// Purpose: Host-side register decoder and map for two serial channels.
// Assumes: Host bus is asynchronous to mclk_i; strobes last several clocks.
// Notes:   Serial engines sit outside; they see the register copies here.

`include "uartdec_defs.vh"

// ==================================================
// One channel's register set
module uartdec_chan #(
  parameter [7:0] REV_CODE = 8'h01,
  parameter [7:0] DEV_ID   = 8'h5a
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [2:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire [7:0]  rx_holding_i,
  input  wire [7:0]  interrupt_status_i,
  input  wire [7:0]  line_status_i,
  input  wire [7:0]  modem_status_i,
  input  wire [7:0]  fifo_count_i,
  input  wire [7:0]  fifo_level_i,
  output reg  [7:0]  rdata_o,
  output reg  [7:0]  tx_data_q,
  output reg         tx_load_q,
  output reg         rx_read_q,
  output reg  [7:0]  fifo_control_q,
  output reg         fifo_control_load_q,
  output reg  [7:0]  trigger_level_q,
  output reg         trigger_load_q,
  output reg  [7:0]  enhanced_mode_select_q,
  output reg         mode_select_load_q,
  output reg  [15:0] divisor_q,
  output reg  [7:0]  line_control_q,
  output reg  [7:0]  interrupt_enable_q,
  output reg  [7:0]  modem_control_q,
  output reg  [7:0]  feature_control_q,
  output reg  [7:0]  enhanced_function_q,
  output reg  [31:0] flow_chars_q
);

  reg  [7:0] scratch_pad_q;
  wire       enh_bank;
  wire       div_bank;
  wire       div_zero;
  wire       enh_on;
  wire       swap;
  wire [7:0] enh_keep;

  // ==================================================
  // Bank selection
  assign enh_bank = (line_control_q == `UARTDEC_ENH_KEY);
  // The key has bit 7 set, so the divisor bank must exclude it
  assign div_bank = line_control_q[`UARTDEC_DIV_BIT] & ~enh_bank;
  assign div_zero = (divisor_q == `UARTDEC_RST_DIV);
  assign enh_on   = enhanced_function_q[`UARTDEC_ENH_EN_BIT];
  assign swap     = feature_control_q[`UARTDEC_SWAP_BIT];
  assign enh_keep = enh_on ? 8'hff : 8'h00;

  // ==================================================
  // Write side
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_data_q              <= `UARTDEC_RST_BYTE;
      tx_load_q              <= 1'b0;
      rx_read_q              <= 1'b0;
      fifo_control_q         <= `UARTDEC_RST_BYTE;
      fifo_control_load_q    <= 1'b0;
      trigger_level_q        <= `UARTDEC_RST_BYTE;
      trigger_load_q         <= 1'b0;
      enhanced_mode_select_q <= `UARTDEC_RST_BYTE;
      mode_select_load_q     <= 1'b0;
      divisor_q              <= `UARTDEC_RST_DIV;
      line_control_q         <= `UARTDEC_RST_BYTE;
      interrupt_enable_q     <= `UARTDEC_RST_BYTE;
      modem_control_q        <= `UARTDEC_RST_BYTE;
      feature_control_q      <= `UARTDEC_RST_BYTE;
      enhanced_function_q    <= `UARTDEC_RST_BYTE;
      flow_chars_q           <= 32'h0000_0000;
      scratch_pad_q          <= `UARTDEC_RST_BYTE;
    end else begin
      tx_load_q           <= 1'b0;
      fifo_control_load_q <= 1'b0;
      trigger_load_q      <= 1'b0;
      mode_select_load_q  <= 1'b0;
      // Reading the receive holding location pops the receive side
      rx_read_q <= rd_i & (addr_i == `UARTDEC_LOC_0) & ~enh_bank & ~div_bank;
      // Enhanced upper bits drop out while the enable is clear
      if (!enh_on) begin
        interrupt_enable_q <= interrupt_enable_q & ~`UARTDEC_IER_ENH;
        modem_control_q    <= modem_control_q & ~`UARTDEC_MCR_ENH;
        fifo_control_q     <= fifo_control_q & ~`UARTDEC_FCR_ENH;
      end
      if (wr_i) begin
        case (addr_i)
          `UARTDEC_LOC_0: begin
            if (enh_bank) begin
              trigger_level_q <= wdata_i;
              trigger_load_q  <= 1'b1;
            end else if (div_bank) begin
              divisor_q[7:0] <= wdata_i;
            end else begin
              tx_data_q <= wdata_i;
              tx_load_q <= 1'b1;
            end
          end
          `UARTDEC_LOC_1: begin
            if (enh_bank) begin
              feature_control_q <= wdata_i;
            end else if (div_bank) begin
              divisor_q[15:8] <= wdata_i;
            end else begin
              interrupt_enable_q <= wdata_i & (~`UARTDEC_IER_ENH | enh_keep);
            end
          end
          `UARTDEC_LOC_2: begin
            if (enh_bank) begin
              enhanced_function_q <= wdata_i;
            end else begin
              fifo_control_q      <= wdata_i & (~`UARTDEC_FCR_ENH | enh_keep);
              fifo_control_load_q <= 1'b1;
            end
          end
          `UARTDEC_LOC_LINE: begin
            line_control_q <= wdata_i;
          end
          `UARTDEC_LOC_4: begin
            if (enh_bank) begin
              flow_chars_q[7:0] <= wdata_i;
            end else begin
              modem_control_q <= wdata_i & (~`UARTDEC_MCR_ENH | enh_keep);
            end
          end
          `UARTDEC_LOC_5: begin
            // Outside the enhanced bank this write is dropped
            if (enh_bank) begin
              flow_chars_q[15:8] <= wdata_i;
            end
          end
          `UARTDEC_LOC_6: begin
            if (enh_bank) begin
              flow_chars_q[23:16] <= wdata_i;
            end
          end
          `UARTDEC_LOC_7: begin
            if (enh_bank) begin
              flow_chars_q[31:24] <= wdata_i;
            end else if (swap) begin
              enhanced_mode_select_q <= wdata_i;
              mode_select_load_q     <= 1'b1;
            end else begin
              scratch_pad_q <= wdata_i;
            end
          end
          default: begin
            scratch_pad_q <= scratch_pad_q;
          end
        endcase
      end
    end
  end

  // ==================================================
  // Read side; purely combinational, so reads never alter stored values
  always @* begin
    rdata_o = `UARTDEC_RST_BYTE;
    case (addr_i)
      `UARTDEC_LOC_0: begin
        if (enh_bank) begin
          rdata_o = fifo_count_i;
        end else if (div_bank) begin
          rdata_o = div_zero ? REV_CODE : divisor_q[7:0];
        end else begin
          rdata_o = rx_holding_i;
        end
      end
      `UARTDEC_LOC_1: begin
        if (enh_bank) begin
          rdata_o = feature_control_q;
        end else if (div_bank) begin
          rdata_o = div_zero ? DEV_ID : divisor_q[15:8];
        end else begin
          rdata_o = interrupt_enable_q;
        end
      end
      `UARTDEC_LOC_2: begin
        if (enh_bank) begin
          rdata_o = enhanced_function_q;
        end else begin
          rdata_o = interrupt_status_i & (~`UARTDEC_ISR_ENH | enh_keep);
        end
      end
      `UARTDEC_LOC_LINE: begin
        rdata_o = line_control_q;
      end
      `UARTDEC_LOC_4: begin
        rdata_o = enh_bank ? flow_chars_q[7:0] : modem_control_q;
      end
      `UARTDEC_LOC_5: begin
        rdata_o = enh_bank ? flow_chars_q[15:8] : line_status_i;
      end
      `UARTDEC_LOC_6: begin
        rdata_o = enh_bank ? flow_chars_q[23:16] : modem_status_i;
      end
      `UARTDEC_LOC_7: begin
        if (enh_bank) begin
          rdata_o = flow_chars_q[31:24];
        end else if (swap) begin
          rdata_o = fifo_level_i;
        end else begin
          rdata_o = scratch_pad_q;
        end
      end
      default: begin
        rdata_o = `UARTDEC_RST_BYTE;
      end
    endcase
  end

endmodule

// ==================================================
// Top: pin synchroniser, channel select and data bus drive
module uartdec_top #(
  parameter [7:0] REV_CODE = 8'h01,
  parameter [7:0] DEV_ID   = 8'h5a
) (
  input  wire        mclk_i,
  input  wire        nrst_i,
  input  wire        chan_a_select_n_i,
  input  wire        chan_b_select_n_i,
  input  wire        reg_sel_bit0_i,
  input  wire        reg_sel_bit1_i,
  input  wire        reg_sel_bit2_i,
  input  wire        rd_n_i,
  input  wire        wr_n_i,
  input  wire [7:0]  data_i,
  output reg  [7:0]  data_o,
  output reg         data_oe_o,
  input  wire [15:0] rx_holding_i,
  input  wire [15:0] interrupt_status_i,
  input  wire [15:0] line_status_i,
  input  wire [15:0] modem_status_i,
  input  wire [15:0] fifo_count_i,
  input  wire [15:0] fifo_level_i,
  output wire [15:0] tx_data_o,
  output wire [1:0]  tx_load_o,
  output wire [1:0]  rx_read_o,
  output wire [15:0] fifo_control_o,
  output wire [1:0]  fifo_control_load_o,
  output wire [15:0] trigger_level_o,
  output wire [1:0]  trigger_load_o,
  output wire [15:0] enhanced_mode_select_o,
  output wire [1:0]  mode_select_load_o,
  output wire [31:0] divisor_o,
  output wire [15:0] line_control_o,
  output wire [15:0] interrupt_enable_o,
  output wire [15:0] modem_control_o,
  output wire [15:0] feature_control_o,
  output wire [15:0] enhanced_function_o,
  output wire [63:0] flow_chars_o
);

  reg  [`UARTDEC_SYNC_W-1:0] sync1_q;
  reg  [`UARTDEC_SYNC_W-1:0] sync2_q;
  reg  [`UARTDEC_SYNC_W-1:0] sync3_q;
  reg  [`UARTDEC_SYNC_W-1:0] pin_q;
  reg  [`UARTDEC_SYNC_W-1:0] pin_prev_q;
  wire [`UARTDEC_SYNC_W-1:0] pins;
  wire [`UARTDEC_SYNC_W-1:0] pin_d;
  wire [1:0]                 sel_now;
  wire [1:0]                 sel_prev;
  wire                       rd_start;
  wire                       wr_end;
  wire [7:0]                 rdata [0:1];

  // ==================================================
  // Three-stage synchroniser; a bit moves once stages two and three agree
  assign pins  = {chan_a_select_n_i, chan_b_select_n_i, reg_sel_bit2_i, reg_sel_bit1_i,
                  reg_sel_bit0_i, rd_n_i, wr_n_i, data_i};
  assign pin_d = (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q    <= `UARTDEC_RST_SYNC;
      sync2_q    <= `UARTDEC_RST_SYNC;
      sync3_q    <= `UARTDEC_RST_SYNC;
      pin_q      <= `UARTDEC_RST_SYNC;
      pin_prev_q <= `UARTDEC_RST_SYNC;
    end else begin
      sync1_q    <= pins;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      pin_q      <= pin_d;
      pin_prev_q <= pin_q;
    end
  end

  // ==================================================
  // Strobes; exactly one select low picks a channel, both low picks none
  assign sel_now  = {~pin_q[13] & pin_q[14], ~pin_q[14] & pin_q[13]};
  assign sel_prev = {~pin_prev_q[13] & pin_prev_q[14], ~pin_prev_q[14] & pin_prev_q[13]};
  assign rd_start = ~pin_q[9] & pin_prev_q[9];
  // Writes commit as the write strobe releases, with the settled data
  assign wr_end   = pin_q[8] & ~pin_prev_q[8];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      uartdec_chan #(
        .REV_CODE (REV_CODE),
        .DEV_ID   (DEV_ID)
      ) u_chan (
        .clk_i                  (mclk_i),
        .nrst_i                 (nrst_i),
        .wr_i                   (wr_end & sel_prev[ch]),
        .rd_i                   (rd_start & sel_now[ch]),
        .addr_i                 (wr_end ? pin_prev_q[12:10] : pin_q[12:10]),
        .wdata_i                (pin_prev_q[7:0]),
        .rx_holding_i           (rx_holding_i[ch*8 +: 8]),
        .interrupt_status_i     (interrupt_status_i[ch*8 +: 8]),
        .line_status_i          (line_status_i[ch*8 +: 8]),
        .modem_status_i         (modem_status_i[ch*8 +: 8]),
        .fifo_count_i           (fifo_count_i[ch*8 +: 8]),
        .fifo_level_i           (fifo_level_i[ch*8 +: 8]),
        .rdata_o                (rdata[ch]),
        .tx_data_q              (tx_data_o[ch*8 +: 8]),
        .tx_load_q              (tx_load_o[ch]),
        .rx_read_q              (rx_read_o[ch]),
        .fifo_control_q         (fifo_control_o[ch*8 +: 8]),
        .fifo_control_load_q    (fifo_control_load_o[ch]),
        .trigger_level_q        (trigger_level_o[ch*8 +: 8]),
        .trigger_load_q         (trigger_load_o[ch]),
        .enhanced_mode_select_q (enhanced_mode_select_o[ch*8 +: 8]),
        .mode_select_load_q     (mode_select_load_o[ch]),
        .divisor_q              (divisor_o[ch*16 +: 16]),
        .line_control_q         (line_control_o[ch*8 +: 8]),
        .interrupt_enable_q     (interrupt_enable_o[ch*8 +: 8]),
        .modem_control_q        (modem_control_o[ch*8 +: 8]),
        .feature_control_q      (feature_control_o[ch*8 +: 8]),
        .enhanced_function_q    (enhanced_function_o[ch*8 +: 8]),
        .flow_chars_q           (flow_chars_o[ch*32 +: 32])
      );
    end
  endgenerate

  // ==================================================
  // Data bus drive; follows live status while the read strobe is held
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o    <= `UARTDEC_RST_BYTE;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= ~pin_q[9] & (sel_now[0] | sel_now[1]);
      data_o    <= sel_now[1] ? rdata[1] : rdata[0];
    end
  end

endmodule

//--- testbench/uart_register_decode_test.sv
// Purpose: Self-checking bench for the dual channel register decoder.
// Assumes: Host model drives the pins; status inputs are fixed levels.
// Notes:   Channel A status bytes begin with a, channel B with b, except interrupt status.
module uart_register_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
  localparam logic [7:0] DID = 8'h6d;  // Arbitrary value
  localparam logic [1:0] CHA = 2'd0, CHB = 2'd1, NONE = 2'd2;
  logic        mclk_i, nrst_i, chan_a_select_n_i, chan_b_select_n_i, rd_n_i, wr_n_i, data_oe_o;
  logic [2:0]  sel;
  logic [7:0]  data_i, data_o;
  logic [15:0] rx_holding_i, interrupt_status_i, line_status_i, modem_status_i, fifo_count_i, fifo_level_i;
  logic [15:0] tx_data_o, fifo_control_o, trigger_level_o, enhanced_mode_select_o, line_control_o;
  logic [15:0] interrupt_enable_o, modem_control_o, feature_control_o, enhanced_function_o;
  logic [1:0]  tx_load_o, rx_read_o, fifo_control_load_o, trigger_load_o, mode_select_load_o;
  logic [31:0] divisor_o;
  logic [63:0] flow_chars_o;
  logic [7:0]  flow_tab [4] = '{8'h11, 8'h13, 8'h91, 8'h93};
  int          err_count = 0, check_count = 0, cycles = 0, pulses = 0;

  uartdec_top #(.REV_CODE(REV), .DEV_ID(DID)) dut (
    .mclk_i, .nrst_i, .chan_a_select_n_i, .chan_b_select_n_i, .reg_sel_bit0_i(sel[0]), .reg_sel_bit1_i(sel[1]),
    .reg_sel_bit2_i(sel[2]), .rd_n_i, .wr_n_i, .data_i, .data_o, .data_oe_o, .rx_holding_i, .interrupt_status_i,
    .line_status_i, .modem_status_i, .fifo_count_i, .fifo_level_i, .tx_data_o, .tx_load_o, .rx_read_o,
    .fifo_control_o, .fifo_control_load_o, .trigger_level_o, .trigger_load_o, .enhanced_mode_select_o,
    .mode_select_load_o, .divisor_o, .line_control_o, .interrupt_enable_o, .modem_control_o, .feature_control_o,
    .enhanced_function_o, .flow_chars_o);
  uartdec_host host (.mclk_i, .data_oe_i(data_oe_o), .rdata_i(data_o), .chan_a_select_n_o(chan_a_select_n_i),
    .chan_b_select_n_o(chan_b_select_n_i), .reg_sel_o(sel), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .wdata_o(data_i));

  // ==================================================
  // Comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [1:0] ch, input logic [2:0] loc, input logic [7:0] exp, input string what);
    logic [7:0] v;
    logic       ok;
    host.rd(ch, loc, v, ok);
    check({ok, v}, {1'b1, exp}, what);
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==================================================
  // Scenarios
  task automatic t_normal;
    logic [7:0] v;
    logic       ok;
    rd_chk(CHA, 3'h3, 8'h00, "line control at reset");
    host.wr(CHA, 3'h3, 8'h03);
    rd_chk(CHA, 3'h0, 8'ha1, "rx data");
    host.wr(CHA, 3'h0, 8'h77);
    check(tx_data_o[7:0], 8'h77, "tx data");
    host.wr(CHA, 3'h1, 8'hff);
    rd_chk(CHA, 3'h1, 8'h0f, "interrupt enable upper bits");
    rd_chk(CHA, 3'h2, 8'hc6, "interrupt status");
    host.wr(CHA, 3'h2, 8'h31);
    check(fifo_control_o[7:0], 8'h01, "fifo control");
    host.wr(CHA, 3'h4, 8'hff);
    rd_chk(CHA, 3'h4, 8'h1f, "modem control");
    host.wr(CHA, 3'h5, 8'h00);
    host.wr(CHA, 3'h6, 8'h00);
    rd_chk(CHA, 3'h5, 8'ha5, "line status");
    rd_chk(CHA, 3'h6, 8'ha6, "modem status");
    check({modem_control_o[7:0], line_control_o[7:0]}, 16'h1f03, "state after reserved writes");
    host.wr(CHA, 3'h7, 8'h5a);
    rd_chk(CHA, 3'h7, 8'h5a, "scratch");
    host.wr(NONE, 3'h7, 8'hee);
    host.rd(NONE, 3'h7, v, ok);
    check(ok, 1'b0, "bus driven with both selects");
    rd_chk(CHA, 3'h7, 8'h5a, "scratch after double select");
  endtask

  task automatic t_chan_b;
    host.wr(CHB, 3'h3, 8'h07);
    rd_chk(CHB, 3'h3, 8'h07, "line control B");
    rd_chk(CHA, 3'h3, 8'h03, "line control A kept");
    rd_chk(CHB, 3'h0, 8'hb1, "rx data B");
    host.wr(CHB, 3'h7, 8'hc3);
    rd_chk(CHA, 3'h7, 8'h5a, "scratch A kept");
    rd_chk(CHB, 3'h7, 8'hc3, "scratch B");
  endtask

  task automatic t_divisor;
    host.wr(CHA, 3'h3, 8'h80);
    rd_chk(CHA, 3'h0, REV, "revision");
    rd_chk(CHA, 3'h1, DID, "device id");
    host.wr(CHA, 3'h0, 8'h34);
    host.wr(CHA, 3'h1, 8'h12);
    check(divisor_o[15:0], 16'h1234, "divisor");
    rd_chk(CHA, 3'h0, 8'h34, "divisor low");
    rd_chk(CHA, 3'h1, 8'h12, "divisor high");
    rd_chk(CHA, 3'h2, 8'hc6, "status in divisor mode");
    host.wr(CHA, 3'h3, 8'h03);
    rd_chk(CHA, 3'h1, 8'h0f, "interrupt enable again");
  endtask

  task automatic t_enhanced;
    host.wr(CHA, 3'h3, 8'hbf);
    host.wr(CHA, 3'h0, 8'h44);
    check(trigger_level_o[7:0], 8'h44, "trigger level");
    rd_chk(CHA, 3'h0, 8'ha0, "fifo count");
    check(trigger_level_o[7:0], 8'h44, "trigger after read");
    host.wr(CHA, 3'h1, 8'h40);
    rd_chk(CHA, 3'h1, 8'h40, "feature control");
    host.wr(CHA, 3'h2, 8'h10);
    rd_chk(CHA, 3'h2, 8'h10, "enhanced function");
    for (int i = 0; i < 4; i++) host.wr(CHA, 3'(4 + i), flow_tab[i]);
    for (int i = 0; i < 4; i++) rd_chk(CHA, 3'(4 + i), flow_tab[i], "flow character");
    check(flow_chars_o[31:0], 32'h9391_1311, "flow characters");
    check(divisor_o[15:0], 16'h1234, "divisor untouched");
    rd_chk(CHA, 3'h3, 8'hbf, "line control key");
    host.wr(CHA, 3'h3, 8'h03);
    host.wr(CHA, 3'h7, 8'ha5);
    check(enhanced_mode_select_o[7:0], 8'ha5, "mode select");
    rd_chk(CHA, 3'h7, 8'ha7, "fifo level");
    host.wr(CHA, 3'h1, 8'hf3);
    rd_chk(CHA, 3'h1, 8'hf3, "interrupt enable full");
    rd_chk(CHA, 3'h2, 8'hf6, "interrupt status full");
    host.wr(CHA, 3'h2, 8'h31);
    check(fifo_control_o[7:0], 8'h31, "fifo control full");
    host.wr(CHA, 3'h4, 8'hff);
    rd_chk(CHA, 3'h4, 8'hff, "modem control full");
    host.wr(CHA, 3'h3, 8'hbf);
    host.wr(CHA, 3'h2, 8'h00);
    host.wr(CHA, 3'h3, 8'h03);
    rd_chk(CHA, 3'h1, 8'h03, "interrupt enable cleared");
    check({modem_control_o[7:0], fifo_control_o[7:0]}, 16'h1f01, "upper bits cleared");
    check(pulses, 7, "load and pop pulses");
  endtask

  // ==================================================
  // Clock, timeout and main sequence
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      conclude();
    end
  end

  // Every load or pop pulse must last exactly one cycle
  always @(negedge mclk_i)
    pulses += $countones({tx_load_o, rx_read_o, fifo_control_load_o, trigger_load_o, mode_select_load_o});

  initial begin
    nrst_i = 1'b0;
    rx_holding_i = 16'hb1a1;
    interrupt_status_i = 16'h33f6;
    line_status_i = 16'hb5a5;
    modem_status_i = 16'hb6a6;
    fifo_count_i = 16'hb0a0;
    fifo_level_i = 16'hb7a7;
    repeat (3) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_normal();
    t_chan_b();
    t_divisor();
    t_enhanced();
    conclude();
  end
endmodule

//--- testbench/uartdec_assertions.sv
// Purpose: Concurrent checks on the decoder pins and channel A register outputs.
// Assumes: Single clock domain; channel B shares the same logic as channel A.
// Notes:   Bound to every uartdec_top instance from the foot of this file.
module uartdec_checker (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        chan_a_select_n_i,
  input wire logic        chan_b_select_n_i,
  input wire logic        rd_n_i,
  input wire logic        wr_n_i,
  input wire logic        data_oe_o,
  input wire logic [1:0]  tx_load_o,
  input wire logic [1:0]  rx_read_o,
  input wire logic [15:0] fifo_control_o,
  input wire logic [1:0]  fifo_control_load_o,
  input wire logic [1:0]  trigger_load_o,
  input wire logic [1:0]  mode_select_load_o,
  input wire logic [31:0] divisor_o,
  input wire logic [15:0] line_control_o,
  input wire logic [15:0] interrupt_enable_o,
  input wire logic [15:0] modem_control_o,
  input wire logic [15:0] feature_control_o,
  input wire logic [15:0] enhanced_function_o,
  input wire logic [63:0] flow_chars_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // ==================================================
  // Helpers
  logic        one_sel;
  logic [7:0]  lcr_a;
  logic [15:0] div_a;
  logic [31:0] flow_a;
  assign one_sel = chan_a_select_n_i ^ chan_b_select_n_i;
  assign lcr_a   = line_control_o[7:0];
  assign div_a   = divisor_o[15:0];
  assign flow_a  = flow_chars_o[31:0];

  // ==================================================
  // Read strobe steps
  sequence s_rd_go; $fell(rd_n_i) && one_sel; endsequence
  sequence s_rd_hold; (!rd_n_i && one_sel)[*6]; endsequence

  // ==================================================
  // Properties
  property p_oe_after_rd; s_rd_go ##1 s_rd_hold |-> data_oe_o; endproperty
  a_oe_after_rd: assert property (p_oe_after_rd) else $error("read not answered");
  property p_oe_selected; $rose(data_oe_o) |-> !rd_n_i && $past(one_sel, 2); endproperty
  a_oe_selected: assert property (p_oe_selected) else $error("bus driven without select");
  property p_data_bank; (tx_load_o[0] || rx_read_o[0]) |-> !lcr_a[7] && !tx_load_o[1]; endproperty
  a_data_bank: assert property (p_data_bank) else $error("data access in wrong bank");
  property p_div_bank; $changed(div_a) |-> lcr_a[7] && lcr_a != 8'hbf; endproperty
  a_div_bank: assert property (p_div_bank) else $error("divisor changed outside its bank");
  property p_fcr_bank; fifo_control_load_o[0] |-> lcr_a != 8'hbf; endproperty
  a_fcr_bank: assert property (p_fcr_bank) else $error("fifo control loaded in enhanced bank");
  property p_enhanced_mode_select_bank; mode_select_load_o[0] |-> lcr_a != 8'hbf && feature_control_o[6]; endproperty
  a_enhanced_mode_select_bank: assert property (p_enhanced_mode_select_bank) else $error("mode select loaded wrongly");
  property p_trg_bank; trigger_load_o[0] |-> lcr_a == 8'hbf; endproperty
  a_trg_bank: assert property (p_trg_bank) else $error("trigger loaded outside enhanced bank");
  property p_flow_bank; $changed(flow_a) |-> lcr_a == 8'hbf; endproperty
  a_flow_bank: assert property (p_flow_bank) else $error("flow character changed wrongly");
  property p_enh_mask;
    (!enhanced_function_o[4])[*3] |-> interrupt_enable_o[7:4] == 4'h0 && modem_control_o[7:5] == 3'h0
      && fifo_control_o[5:4] == 2'h0;
  endproperty
  a_enh_mask: assert property (p_enh_mask) else $error("enhanced bits active while disabled");
  property p_write_only; $changed(lcr_a) |-> wr_n_i && $past(wr_n_i, 7) == 1'b0; endproperty
  a_write_only: assert property (p_write_only) else $error("line control changed without write");
endmodule

bind uartdec_top uartdec_checker chk (.mclk_i, .nrst_i, .chan_a_select_n_i, .chan_b_select_n_i, .rd_n_i,
  .wr_n_i, .data_oe_o, .tx_load_o, .rx_read_o, .fifo_control_o, .fifo_control_load_o, .trigger_load_o,
  .mode_select_load_o, .divisor_o, .line_control_o, .interrupt_enable_o, .modem_control_o,
  .feature_control_o, .enhanced_function_o, .flow_chars_o);

//--- testbench/uartdec_host.sv
// Purpose: Host processor model driving the decoder's asynchronous bus pins.
// Assumes: Pins change on the falling clock edge; strobes held past the synchroniser.
// Notes:   Released address and data pins show inverted values, never stale ones.
module uartdec_host (
  input  wire logic       mclk_i,
  input  wire logic       data_oe_i,
  input  wire logic [7:0] rdata_i,
  output logic            chan_a_select_n_o,
  output logic            chan_b_select_n_o,
  output logic [2:0]      reg_sel_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [7:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chan_a_select_n_o = 1'b1;
    chan_b_select_n_o = 1'b1;
    reg_sel_o = 3'h0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wdata_o = 8'h00;
  end

  // ==================================================
  // Access steps; channel code 0 is A, 1 is B, 2 drives both selects
  task automatic start(input logic [1:0] ch, input logic [2:0] loc);
    @(negedge mclk_i);
    chan_a_select_n_o = (ch == 2'd1);
    chan_b_select_n_o = (ch == 2'd0);
    reg_sel_o = loc;
  endtask

  task automatic finish_acc;
    repeat (5) @(negedge mclk_i);  // Hold pins past the synchroniser
    chan_a_select_n_o = 1'b1;
    chan_b_select_n_o = 1'b1;
    reg_sel_o = ~reg_sel_o;
    wdata_o = ~wdata_o;
    repeat (3) @(negedge mclk_i);
  endtask

  task automatic wr(input logic [1:0] ch, input logic [2:0] loc, input logic [7:0] val);
    start(ch, loc);
    wdata_o = val;
    wr_n_o = 1'b0;
    repeat (7) @(negedge mclk_i);
    wr_n_o = 1'b1;
    finish_acc();
  endtask

  task automatic rd(input logic [1:0] ch, input logic [2:0] loc, output logic [7:0] val, output logic seen);
    start(ch, loc);
    rd_n_o = 1'b0;
    repeat (7) @(negedge mclk_i);  // Sample off the clock edge, well after the answer settles
    seen = data_oe_i;
    val = rdata_i;
    @(negedge mclk_i);
    rd_n_o = 1'b1;
    finish_acc();
  endtask
endmodule
